// File: dv/lfb_led_bank.sv
// behavioural bank of four external indicator lamps, counting lit cycles per lamp
// assumes lamp drive is high while lit and settles between core_clk edges
`timescale 1ns/1ps
module lfb_led_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // bench control
    input wire logic clr,
    // lamp drive, index 0 link/activity up to 3 low speed
    input wire logic [3:0] lamp,
    output logic [3:0][15:0] lit_cnt
);
    // a lamp only integrates light, so a count per lamp is all it can report
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lit_cnt <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                lit_cnt[i] <= clr ? 16'h0000 : lit_cnt[i] + {15'h0000, lamp[i]};
            end
        end
    end
endmodule

// File: dv/lfb_led_ctrl_test.sv
// self-checking bench for the indicator function and blink block
// assumes a 100 MHz core clock and a base tick shortened to 4 cycles
`timescale 1ns/1ps
module lfb_led_ctrl_test;
    localparam int TICK = 4;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [lfb_pkg::ADDR_W-1:0] reg_addr = 5'h00;
    logic [lfb_pkg::DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [lfb_pkg::DATA_W-1:0] reg_rdata;
    logic [3:0] strap = 4'hE;
    lfb_pkg::lfb_status_t phy_status = '0;
    wire logic [3:0] leds;
    logic clr = 1'b0;
    logic [3:0][15:0] lit_cnt;
    int fails = 0;
    int samples_checked = 0;
    lfb_pkg::lfb_status_t st_tab [6];

    always #5 core_clk = ~core_clk;

    lfb_led_ctrl #(.BASE_TICK_CYCLES(TICK)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .indicator_config_strap(strap), .phy_status(phy_status),
        .link_activity_indicator(leds[0]), .gig_speed_indicator(leds[1]),
        .mid_speed_indicator(leds[2]), .low_speed_indicator(leds[3])
    );

    lfb_led_bank led_u (
        .core_clk(core_clk), .nrst(nrst), .clr(clr), .lamp(leds), .lit_cnt(lit_cnt)
    );

    task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_leds(input logic [3:0] got, input logic [3:0] exp);
        check_reg({12'h000, got}, {12'h000, exp});
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check_reg(reg_rdata, exp);
    endtask

    // lamp expectation, blk is the current pattern bit
    function automatic logic exp_lamp(input logic [3:0] c, input logic ext,
            input lfb_pkg::lfb_status_t s, input logic blk);
        logic act;
        logic lk;
        act = s.tx_act | s.rx_act;
        lk = s.link_up;
        if (ext && c == 4'h0)
            return lk && (s.speed == lfb_pkg::SPD_10 || s.speed == lfb_pkg::SPD_100);
        if (ext && c == 4'h3)
            return lk && s.speed == lfb_pkg::SPD_100 && (act ? blk : 1'b1);
        case (c)
            4'h0: return lk && s.speed == lfb_pkg::SPD_1000;
            4'h1: return lk && s.speed == lfb_pkg::SPD_100;
            4'h2: return lk && s.speed == lfb_pkg::SPD_10;
            4'h3: return lk && (s.speed == lfb_pkg::SPD_1000 ||
                                (s.speed == lfb_pkg::SPD_100 && blk));
            4'h4: return lk;
            4'h5: return s.tx_act;
            4'h6: return s.rx_act;
            4'h7: return act;
            4'h8: return lk && s.full_duplex;
            4'h9: return s.collision;
            4'hA: return lk && (act ? blk : 1'b1);
            4'hB: return lk && (s.rx_act ? blk : 1'b1);
            4'hC: return s.full_duplex && (s.rx_act ? blk : 1'b1);
            4'hD: return blk;
            4'hE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // reset with a strap code; fresh pattern index gives bit 0 of 0x55, lit
    task automatic t_reset(input logic [3:0] code);
        @(posedge core_clk);
        strap <= code;
        nrst <= 1'b0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        reg_read(lfb_pkg::REG_FUNC_SEL, {4{code}});
        reg_read(lfb_pkg::REG_BLINK, 16'h1F55);
        reg_read(lfb_pkg::REG_EXT_SEL, 16'h0000);
        check_leds(leds, {4{exp_lamp(code, 1'b0, phy_status, 1'b1)}});
        $display("test reset %h done", code);
    endtask

    task automatic t_regs;
        logic [15:0] w;
        reg_write(lfb_pkg::REG_FUNC_SEL, 16'h4E7B);
        reg_read(lfb_pkg::REG_FUNC_SEL, 16'h4E7B);
        reg_write(5'h05, 16'hFFFF);
        reg_read(5'h05, 16'h0000);
        reg_read(lfb_pkg::REG_FUNC_SEL, 16'h4E7B);
        reg_write(lfb_pkg::REG_EXT_SEL, 16'hFFFF);
        reg_read(lfb_pkg::REG_EXT_SEL, 16'h3C00);
        for (int k = 0; k < 4; k++)
        begin
            w = {2'(k), 6'(k + 5), 8'(8'hA0 + k)};
            reg_write(lfb_pkg::REG_BLINK, w);
            reg_read(lfb_pkg::REG_BLINK, w);
        end
        $display("test registers done");
    endtask

    // every code on every lamp, patterns held all-off then all-on so blink is fixed
    task automatic t_decode;
        logic [3:0] xm [3] = '{4'h0, 4'hF, 4'h6};
        logic [3:0] exp;
        logic [15:0] fs;
        for (int b = 0; b < 2; b++)
        begin
            for (int k = 0; k < 4; k++)
                reg_write(lfb_pkg::REG_BLINK, {2'(k), 6'h00, {8{b[0]}}});
            for (int m = 0; m < 3; m++)
            begin
                reg_write(lfb_pkg::REG_EXT_SEL, {2'b00, xm[m], 10'h000});
                for (int c = 0; c < 16; c++)
                begin
                    for (int i = 0; i < 4; i++)
                        fs[4*i +: 4] = 4'(c + i);
                    reg_write(lfb_pkg::REG_FUNC_SEL, fs);
                    for (int s = 0; s < 6; s++)
                    begin
                        @(posedge core_clk);
                        phy_status <= st_tab[s];
                        repeat (2) @(posedge core_clk);
                        #1;
                        for (int i = 0; i < 4; i++)
                            exp[i] = exp_lamp(fs[4*i +: 4], xm[m][i], st_tab[s], b[0]);
                        check_leds(leds, exp);
                    end
                end
            end
        end
        $display("test decode done");
    endtask

    // window spans whole pattern periods, so the count does not depend on phase
    task automatic count_lit(input int n, input logic [63:0] exp);
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
        for (int i = 0; i < 4; i++)
            check_reg(lit_cnt[i], exp[16*i +: 16]);
    endtask

    task automatic t_blink;
        reg_write(lfb_pkg::REG_EXT_SEL, 16'h0000);
        reg_write(lfb_pkg::REG_FUNC_SEL, 16'hDDDD);
        reg_write(lfb_pkg::REG_BLINK, 16'h0001);
        reg_write(lfb_pkg::REG_BLINK, 16'h4103);
        reg_write(lfb_pkg::REG_BLINK, 16'h800F);
        reg_write(lfb_pkg::REG_BLINK, 16'hC301);
        repeat (300) @(posedge core_clk);
        count_lit(128, {16'h0010, 16'h0040, 16'h0020, 16'h0010});
        $display("test blink done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        st_tab = '{7'b1011000, 7'b0110101, 7'b0011010, 7'b0101010, 7'b1010110, 7'b0111000};
        t_reset(4'hE);
        t_regs;
        t_decode;
        t_blink;
        t_reset(4'h4);
        t_reset(4'hD);
        count_lit(1024, {4{16'h0200}});
        $display("test default blink done");
        final_report;
    end

    // run needs about 3500 cycles; allow some 30000
    initial
    begin
        #300000;
        fails++;
        final_report;
    end
endmodule

// File: shared/lfb_pkg.sv
// constants, field layouts and carrier types for the indicator function and blink block
// assumes a 100 MHz core clock and a 5-bit management register index
package lfb_pkg;

    // register port
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] REG_EXT_SEL = 5'h1B;
    localparam logic [4:0] REG_FUNC_SEL = 5'h1C;
    localparam logic [4:0] REG_BLINK = 5'h1D;

    // indicator indices, also the pattern set codes
    localparam int N_LED = 4;
    localparam int IDX_LNK = 0;
    localparam int IDX_GIG = 1;
    localparam int IDX_MID = 2;
    localparam int IDX_LOW = 3;

    // function select register layout
    localparam int FN_W = 4;

    // extended select register layout
    localparam int EXT_LSB = 10;
    localparam logic [3:0] EXT_RST = 4'h0;

    // blink register layout
    localparam int SEL_LSB = 14;
    localparam int SEL_W = 2;
    localparam int RATIO_LSB = 8;
    localparam int RATIO_W = 6;
    localparam int PAT_LSB = 0;
    localparam int PAT_W = 8;
    localparam int IDX_W = 3;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [5:0] RATIO_RST = 6'h1F;
    localparam logic [7:0] PAT_RST = 8'h55;

    // base tick: default ratio and pattern give a 512 ms blink period
    localparam int CLK_HZ = 100000000;
    localparam int BASE_TICK_MS = 8;
    localparam int BASE_TICK_CYCLES_DEF = BASE_TICK_MS * (CLK_HZ / 1000);
    localparam int TICK_CNT_W = 20;

    // link speed encoding
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    // function codes, standard table
    localparam logic [3:0] FN_GIG = 4'h0;
    localparam logic [3:0] FN_MID = 4'h1;
    localparam logic [3:0] FN_LOW = 4'h2;
    localparam logic [3:0] FN_GIG_MIDBLK = 4'h3;
    localparam logic [3:0] FN_LINK = 4'h4;
    localparam logic [3:0] FN_TX = 4'h5;
    localparam logic [3:0] FN_RX = 4'h6;
    localparam logic [3:0] FN_TXRX = 4'h7;
    localparam logic [3:0] FN_FDX = 4'h8;
    localparam logic [3:0] FN_COLL = 4'h9;
    localparam logic [3:0] FN_LINK_ACT = 4'hA;
    localparam logic [3:0] FN_LINK_RX = 4'hB;
    localparam logic [3:0] FN_FDX_RX = 4'hC;
    localparam logic [3:0] FN_BLINK = 4'hD;
    localparam logic [3:0] FN_ON = 4'hE;
    localparam logic [3:0] FN_OFF = 4'hF;

    // function codes, extended table
    localparam logic [3:0] FNX_LOW_MID = 4'h0;
    localparam logic [3:0] FNX_MID_ACT = 4'h3;

    typedef struct packed {
        logic [1:0] speed;
        logic link_up;
        logic full_duplex;
        logic tx_act;
        logic rx_act;
        logic collision;
    } lfb_status_t;

endpackage

// File: verilog/lfb_blink_gen.sv
// one blink pattern sequencer: divides the base tick and walks the pattern bits
// assumes base_tick is a one-cycle enable from the parent prescaler
`timescale 1ns/1ps
module lfb_blink_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // timing
    input wire logic base_tick,
    input wire logic [lfb_pkg::RATIO_W-1:0] ratio,
    // pattern
    input wire logic [lfb_pkg::PAT_W-1:0] pattern,
    output logic blink_bit,
    output logic step
);

    logic [lfb_pkg::RATIO_W-1:0] div_cnt;
    logic [lfb_pkg::IDX_W-1:0] bit_idx;
    logic [lfb_pkg::RATIO_W-1:0] next_div;
    logic last_div;

    // >= so a ratio lowered mid-count cannot strand the counter
    assign last_div = div_cnt >= ratio;
    assign step = base_tick & last_div;
    assign next_div = step ? '0 : lfb_pkg::RATIO_W'(div_cnt + 1'b1);
    assign blink_bit = pattern[bit_idx];

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_cnt <= '0;
            bit_idx <= '0;
        end
        else if (base_tick)
        begin
            div_cnt <= next_div;
            if (step)
            begin
                bit_idx <= lfb_pkg::IDX_W'(bit_idx + 1'b1);
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_step_advance;
        step |=> bit_idx == lfb_pkg::IDX_W'($past(bit_idx) + 1'b1);
    endproperty
    a_step_advance: assert property (p_step_advance)
        else $error("pattern index did not advance on step");

    property p_idx_hold;
        !step |=> $stable(bit_idx);
    endproperty
    a_idx_hold: assert property (p_idx_hold)
        else $error("pattern index moved without step");

endmodule

// File: verilog/lfb_led_ctrl.sv
// indicator function select and blink pattern control, top level
// assumes register strobes and status inputs synchronous to core_clk
`timescale 1ns/1ps
module lfb_led_ctrl #(
    parameter int unsigned BASE_TICK_CYCLES = lfb_pkg::BASE_TICK_CYCLES_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [lfb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lfb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lfb_pkg::DATA_W-1:0] reg_rdata,
    // configuration strap
    input wire logic [lfb_pkg::FN_W-1:0] indicator_config_strap,
    // link status
    input wire lfb_pkg::lfb_status_t phy_status,
    // indicator outputs, high = lit
    output logic link_activity_indicator,
    output logic gig_speed_indicator,
    output logic mid_speed_indicator,
    output logic low_speed_indicator
);

    localparam int N = lfb_pkg::N_LED;
    localparam int FW = lfb_pkg::FN_W;
    localparam int RW = lfb_pkg::RATIO_W;
    localparam int PW = lfb_pkg::PAT_W;
    localparam int SW = lfb_pkg::SEL_W;
    localparam logic [lfb_pkg::TICK_CNT_W-1:0] TICK_LAST =
        lfb_pkg::TICK_CNT_W'(BASE_TICK_CYCLES - 1);

    // register state
    logic [N*FW-1:0] func_sel;
    logic [N-1:0] ext_sel;
    logic [SW-1:0] pat_sel;
    logic [RW-1:0] ratio_mem [N];
    logic [PW-1:0] pat_mem [N];
    logic strap_pending;

    // block state
    logic [lfb_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic base_tick;
    logic [N-1:0] blink_bits;
    logic [N-1:0] blink_steps;
    logic [N-1:0] led_q;
    logic [N-1:0] next_led;

    // decode
    wire wr_func = reg_wr && (reg_addr == lfb_pkg::REG_FUNC_SEL);
    wire wr_ext = reg_wr && (reg_addr == lfb_pkg::REG_EXT_SEL);
    wire wr_blink = reg_wr && (reg_addr == lfb_pkg::REG_BLINK);
    wire [SW-1:0] wr_set = reg_wdata[lfb_pkg::SEL_LSB +: SW];
    wire [RW-1:0] wr_ratio = reg_wdata[lfb_pkg::RATIO_LSB +: RW];
    wire [PW-1:0] wr_pat = reg_wdata[lfb_pkg::PAT_LSB +: PW];

    // read selection
    wire [lfb_pkg::DATA_W-1:0] rd_func = func_sel;
    wire [lfb_pkg::DATA_W-1:0] rd_ext =
        lfb_pkg::DATA_W'({ext_sel, {lfb_pkg::EXT_LSB{1'b0}}});
    wire [lfb_pkg::DATA_W-1:0] rd_blink =
        {pat_sel, ratio_mem[pat_sel], pat_mem[pat_sel]};
    wire [lfb_pkg::DATA_W-1:0] rd_mux =
        (reg_addr == lfb_pkg::REG_FUNC_SEL) ? rd_func :
        (reg_addr == lfb_pkg::REG_EXT_SEL) ? rd_ext :
        (reg_addr == lfb_pkg::REG_BLINK) ? rd_blink : '0;

    // strap is caught on the first edge after reset release, not by the reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strap_pending <= 1'b1;
            func_sel <= '0;
        end
        else if (strap_pending)
        begin
            strap_pending <= 1'b0;
            func_sel <= {N{indicator_config_strap}};
        end
        else if (wr_func)
        begin
            func_sel <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_sel <= lfb_pkg::EXT_RST;
        end
        else if (wr_ext)
        begin
            ext_sel <= reg_wdata[lfb_pkg::EXT_LSB +: N];
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pat_sel <= lfb_pkg::SEL_RST;
        end
        else if (wr_blink)
        begin
            pat_sel <= wr_set;
        end
    end

    // one ratio/pattern pair per indicator, written through the selected set
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_set
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    ratio_mem[g] <= lfb_pkg::RATIO_RST;
                    pat_mem[g] <= lfb_pkg::PAT_RST;
                end
                else if (wr_blink && (wr_set == SW'(g)))
                begin
                    ratio_mem[g] <= wr_ratio;
                    pat_mem[g] <= wr_pat;
                end
            end

            lfb_blink_gen u_blink (
                .core_clk(core_clk),
                .nrst(nrst),
                .base_tick(base_tick),
                .ratio(ratio_mem[g]),
                .pattern(pat_mem[g]),
                .blink_bit(blink_bits[g]),
                .step(blink_steps[g])
            );

            assign next_led[g] = lfb_decode(func_sel[g*FW +: FW], ext_sel[g],
                phy_status, blink_bits[g]);
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= '0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // shared prescaler; each indicator divides it further by its ratio plus one
    assign base_tick = (tick_cnt == TICK_LAST);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt <= '0;
        end
        else
        begin
            tick_cnt <= base_tick ? '0 : lfb_pkg::TICK_CNT_W'(tick_cnt + 1'b1);
        end
    end

    // speed functions are gated by link so a stale speed code stays dark
    function automatic logic lfb_decode(
        input logic [3:0] code,
        input logic ext,
        input lfb_pkg::lfb_status_t st,
        input logic blk
    );
        logic act;
        logic gig;
        logic mid;
        logic low;
        logic res;
        begin
            act = st.tx_act | st.rx_act;
            gig = st.link_up && (st.speed == lfb_pkg::SPD_1000);
            mid = st.link_up && (st.speed == lfb_pkg::SPD_100);
            low = st.link_up && (st.speed == lfb_pkg::SPD_10);
            res = 1'b0;
            if (ext && (code == lfb_pkg::FNX_LOW_MID))
            begin
                res = low | mid;
            end
            else if (ext && (code == lfb_pkg::FNX_MID_ACT))
            begin
                res = mid && (act ? blk : 1'b1);
            end
            else
            begin
                unique case (code)
                    lfb_pkg::FN_GIG: res = gig;
                    lfb_pkg::FN_MID: res = mid;
                    lfb_pkg::FN_LOW: res = low;
                    lfb_pkg::FN_GIG_MIDBLK: res = gig | (mid & blk);
                    lfb_pkg::FN_LINK: res = st.link_up;
                    lfb_pkg::FN_TX: res = st.tx_act;
                    lfb_pkg::FN_RX: res = st.rx_act;
                    lfb_pkg::FN_TXRX: res = act;
                    lfb_pkg::FN_FDX: res = st.link_up & st.full_duplex;
                    lfb_pkg::FN_COLL: res = st.collision;
                    lfb_pkg::FN_LINK_ACT: res = st.link_up && (act ? blk : 1'b1);
                    lfb_pkg::FN_LINK_RX: res = st.link_up && (st.rx_act ? blk : 1'b1);
                    lfb_pkg::FN_FDX_RX: res = st.full_duplex && (st.rx_act ? blk : 1'b1);
                    lfb_pkg::FN_BLINK: res = blk;
                    lfb_pkg::FN_ON: res = 1'b1;
                    lfb_pkg::FN_OFF: res = 1'b0;
                endcase
            end
            lfb_decode = res;
        end
    endfunction

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            led_q <= '0;
        end
        else
        begin
            led_q <= next_led;
        end
    end

    assign link_activity_indicator = led_q[lfb_pkg::IDX_LNK];
    assign gig_speed_indicator = led_q[lfb_pkg::IDX_GIG];
    assign mid_speed_indicator = led_q[lfb_pkg::IDX_MID];
    assign low_speed_indicator = led_q[lfb_pkg::IDX_LOW];

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    wire [3:0] code_lnk = func_sel[lfb_pkg::IDX_LNK*FW +: FW];
    wire [3:0] code_gig = func_sel[lfb_pkg::IDX_GIG*FW +: FW];
    wire [3:0] code_low = func_sel[lfb_pkg::IDX_LOW*FW +: FW];
    wire std_lnk = !ext_sel[lfb_pkg::IDX_LNK];

    sequence s_blink_write;
        wr_blink;
    endsequence

    sequence s_set_updated;
        ratio_mem[$past(wr_set)] == $past(wr_ratio)
            && pat_mem[$past(wr_set)] == $past(wr_pat);
    endsequence

    property p_func_write;
        wr_func && !strap_pending |=> func_sel == $past(reg_wdata);
    endproperty
    a_func_write: assert property (p_func_write)
        else $error("function select write not stored");

    property p_low_field;
        wr_func && !strap_pending |=> code_low == $past(reg_wdata[15:12]);
    endproperty
    a_low_field: assert property (p_low_field)
        else $error("low speed field misplaced");

    property p_std_gig;
        code_lnk == lfb_pkg::FN_GIG && std_lnk && phy_status.link_up
            && phy_status.speed == lfb_pkg::SPD_1000 |=> link_activity_indicator;
    endproperty
    a_std_gig: assert property (p_std_gig)
        else $error("gigabit code did not light indicator");

    property p_std_idle;
        code_lnk == lfb_pkg::FN_TXRX && std_lnk
            && !phy_status.tx_act && !phy_status.rx_act |=> !link_activity_indicator;
    endproperty
    a_std_idle: assert property (p_std_idle)
        else $error("activity code lit without activity");

    property p_coll;
        code_gig == lfb_pkg::FN_COLL && !ext_sel[lfb_pkg::IDX_GIG]
            && phy_status.collision |=> gig_speed_indicator;
    endproperty
    a_coll: assert property (p_coll)
        else $error("collision code did not light indicator");

    property p_link_steady;
        code_lnk == lfb_pkg::FN_LINK_ACT && std_lnk && phy_status.link_up
            && !phy_status.tx_act && !phy_status.rx_act |=> link_activity_indicator;
    endproperty
    a_link_steady: assert property (p_link_steady)
        else $error("link without activity not steady on");

    property p_blink_follow;
        code_lnk == lfb_pkg::FN_BLINK && std_lnk
            |=> link_activity_indicator == $past(blink_bits[lfb_pkg::IDX_LNK]);
    endproperty
    a_blink_follow: assert property (p_blink_follow)
        else $error("blink code does not follow pattern");

    property p_forced_off;
        code_lnk == lfb_pkg::FN_OFF && std_lnk |=> !link_activity_indicator;
    endproperty
    a_forced_off: assert property (p_forced_off)
        else $error("forced off indicator lit");

    property p_ext_mid;
        code_lnk == lfb_pkg::FNX_LOW_MID && !std_lnk && phy_status.link_up
            && phy_status.speed == lfb_pkg::SPD_100 |=> link_activity_indicator;
    endproperty
    a_ext_mid: assert property (p_ext_mid)
        else $error("extended low/mid code did not light at 100");

    // sampled nrst keeps the release edge itself, where the load is still pending, out
    property p_strap_load;
        nrst && strap_pending
            |=> func_sel == {N{$past(indicator_config_strap)}} && !strap_pending;
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("strap not loaded into function fields");

    property p_sel_write;
        s_blink_write |=> pat_sel == $past(wr_set);
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("pattern set selector not updated");

    property p_set_write;
        s_blink_write |=> s_set_updated;
    endproperty
    a_set_write: assert property (p_set_write)
        else $error("selected pattern set not written");

    property p_blink_read;
        reg_rd && reg_addr == lfb_pkg::REG_BLINK
            |=> reg_rdata == {$past(pat_sel), $past(rd_blink[13:0])};
    endproperty
    a_blink_read: assert property (p_blink_read)
        else $error("blink register read wrong set");

    property p_ext_write;
        wr_ext |=> ext_sel == $past(reg_wdata[13:10]);
    endproperty
    a_ext_write: assert property (p_ext_write)
        else $error("extended select write not stored");

    property p_ratio0_step;
        base_tick && ratio_mem[lfb_pkg::IDX_LNK] == '0 |-> blink_steps[lfb_pkg::IDX_LNK];
    endproperty
    a_ratio0_step: assert property (p_ratio0_step)
        else $error("zero ratio did not step on base tick");

endmodule
